// ==== include/mode_pkg.sv ====
// Purpose: Shared constants and types of the serial mode control block
// Assumes: 200 MHz hclk, fixed bit rate
// Notes:   Register offsets are byte addresses on AHB-Lite
package mode_pkg;
   // ------------------------------------------------------------
   // Register map and fields
   // ------------------------------------------------------------
   localparam logic [7:0] A_CMD   = 8'h00;
   localparam logic [7:0] A_MODE  = 8'h04;
   localparam logic [7:0] A_STAT  = 8'h08;
   localparam logic [7:0] A_DATA  = 8'h0C;
   localparam logic [7:0] A_ISTAT = 8'h10;
   localparam logic [7:0] A_ICLR  = 8'h14;
   localparam logic [7:0] A_IEN   = 8'h18;
   localparam int CMD_MODE_LSB = 6;
   localparam int CMD_RXEN     = 2;
   localparam int CMD_TXEN     = 0;
   localparam int MODE_SL_LSB  = 0;
   localparam int MODE_PEN     = 2;
   localparam int MODE_PODD    = 3;
   localparam int ST_TRANSMIT_READY     = 0;
   localparam int ST_RECEIVE_READY     = 1;
   localparam int ST_TRANSMITTER_EMPTY     = 2;
   localparam logic [1:0] CM_NORMAL = 2'h0;
   localparam logic [1:0] CM_ECHO   = 2'h1;
   localparam logic [1:0] CM_LOCAL  = 2'h2;
   localparam logic [1:0] CM_REMOTE = 2'h3;
   localparam logic [1:0] SL_TWO    = 2'h3;
   localparam logic [7:0] CMD_RST   = 8'h00;
   localparam logic [7:0] MODE_RST  = 8'h01;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_HZ  = 200000000;
   localparam int BAUD_HZ = 115200;
   localparam logic [11:0] BIT_CYC  = 12'(CLK_HZ / BAUD_HZ);
   localparam logic [11:0] HALF_CYC = 12'(CLK_HZ / BAUD_HZ / 2);
   localparam logic [2:0]  LAST_BIT = 3'h7;
   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef struct packed {
      logic [1:0] mode;
      logic       rx_en;
      logic       tx_en;
   } cmd_t;
   typedef struct packed {
      logic [1:0] stop_len;
      logic       par_en;
      logic       par_odd;
   } cfg_t;
   typedef enum logic [2:0] {
      S_IDLE  = 3'b000,
      S_START = 3'b001,
      S_DATA  = 3'b010,
      S_PAR   = 3'b011,
      S_STOP  = 3'b100
   } ser_st_t;
endpackage

// ==== logic/bit_timer.sv ====
// Purpose: Bit period timer, pulses at mid bit and end of bit
// Assumes: Restart pulse aligns the period to a frame edge
// Notes:   Free running between restarts
`timescale 1ns/1ps
`default_nettype none
module bit_timer
   import mode_pkg::*;
(
   // Clock, reset and enable
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic ce,
   // Control and ticks
   input  wire logic restart,
   output logic      mid,
   output logic      full
);
   logic [11:0] cnt_r;
   wire         wrap = (cnt_r == BIT_CYC - 12'h001);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_r <= 12'h000;
      end else if (ce) begin
         cnt_r <= (restart || wrap) ? 12'h000 : cnt_r + 12'h001;
      end
   end

   assign mid  = ce && !restart && (cnt_r == HALF_CYC - 12'h001);
   assign full = ce && !restart && wrap;
endmodule // bit_timer
`default_nettype wire

// ==== logic/serial_mode_ctrl.sv ====
// Purpose: Serial channel with normal, echo, local and remote loop modes
// Assumes: AHB-Lite single word transfers, 8 data bits per character
// Notes:   Zero wait state slave; ce low freezes all state
`timescale 1ns/1ps
`default_nettype none
module serial_mode_ctrl
   import mode_pkg::*;
(
   // Clock, reset, enable
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        ce,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Serial line
   input  wire logic        rx_line,
   output logic             tx_line,
   // Status pins
   output logic             tx_empty_or_line_change_pin_n,
   output logic             irq
);
   // ------------------------------------------------------------
   // Decode helpers
   // ------------------------------------------------------------
   function automatic logic echo_like(input logic [1:0] m);
      echo_like = (m == CM_ECHO) || (m == CM_REMOTE);
   endfunction

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   cmd_t        cmd_r;
   cfg_t        cfg_r;
   logic [7:0]  thr_r;
   logic        thr_full_r;
   logic [7:0]  rx_data_r;
   logic        receive_ready_r;
   logic [2:0]  ist_r;
   logic [2:0]  ien_r;
   logic        wr_pend_r;
   logic [7:0]  wr_addr_r;
   logic        rx_s1_r;
   logic        rx_s2_r;
   ser_st_t     tx_st_r;
   ser_st_t     rx_st_r;
   logic [2:0]  tx_bit_r;
   logic [2:0]  rx_bit_r;
   logic        tx_stopn_r;
   logic [7:0]  tx_sh_r;
   logic [7:0]  rx_sh_r;
   logic        tx_par_r;
   logic        rx_par_r;
   logic        undr_r;
   logic        echo_pend_r;
   logic        echo_done_r;
   logic        tx_empty_r;
   logic        prev_transmit_ready_r;
   logic        prev_receive_ready_r;
   logic        prev_emt_r;
   logic        tx_line_r;
   logic [31:0] hrdata_r;
   logic        hreadyout_r;
   logic        irq_r;
   logic        tx_mid;
   logic        tx_full;
   logic        rx_mid;
   logic        rx_full;
   logic        line_nxt;

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   wire       addr_ph  = ce && hsel && htrans[1] && hready;
   wire       rd_ph    = addr_ph && !hwrite;
   wire [7:0] a_lo     = haddr[7:0];
   wire       wr_cmd   = wr_pend_r && (wr_addr_r == A_CMD);
   wire       wr_mode  = wr_pend_r && (wr_addr_r == A_MODE);
   wire       wr_data  = wr_pend_r && (wr_addr_r == A_DATA);
   wire       wr_iclr  = wr_pend_r && (wr_addr_r == A_ICLR);
   wire       wr_ien   = wr_pend_r && (wr_addr_r == A_IEN);
   wire       rd_data  = rd_ph && (a_lo == A_DATA);
   wire [2:0] stat     = {tx_empty_r, receive_ready_r, !thr_full_r};
   wire [7:0] cmd_rd   = {cmd_r.mode, 3'h0, cmd_r.rx_en, 1'b0, cmd_r.tx_en};
   wire [3:0] mode_rd  = {cfg_r.par_odd, cfg_r.par_en, cfg_r.stop_len};
   wire [31:0] rd_mux  =
      (a_lo == A_CMD)   ? {24'h000000, cmd_rd} :
      (a_lo == A_MODE)  ? {28'h0000000, mode_rd} :
      (a_lo == A_STAT)  ? {29'h00000000, stat} :
      (a_lo == A_DATA)  ? {24'h000000, rx_data_r} :
      (a_lo == A_ISTAT) ? {29'h00000000, ist_r} :
      (a_lo == A_IEN)   ? {29'h00000000, ien_r} : 32'h00000000;

   // ------------------------------------------------------------
   // Mode decode
   // ------------------------------------------------------------
   wire echo_mode = (cmd_r.mode == CM_ECHO);
   wire echo_path = echo_like(cmd_r.mode);
   wire rx_run    = cmd_r.rx_en;
   // Local loop feeds transmit data straight back, line held idle
   wire rx_in     = (cmd_r.mode == CM_LOCAL) ? line_nxt : rx_s2_r;
   wire two_stop  = (cfg_r.stop_len == SL_TWO);

   // ------------------------------------------------------------
   // Bus slave registers
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r   <= 1'b0;
         wr_addr_r   <= 8'h00;
         hrdata_r    <= 32'h00000000;
         hreadyout_r <= 1'b0;
      end else if (ce) begin
         hreadyout_r <= 1'b1;
         wr_pend_r   <= addr_ph && hwrite;
         wr_addr_r   <= a_lo;
         if (rd_ph) begin
            hrdata_r <= rd_mux;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmd_r <= cmd_t'({CMD_RST[7:6], CMD_RST[2], CMD_RST[0]});
         cfg_r <= cfg_t'({MODE_RST[MODE_SL_LSB +: 2], MODE_RST[MODE_PEN], MODE_RST[MODE_PODD]});
         ien_r <= 3'h0;
      end else if (ce) begin
         if (wr_cmd) begin
            // Mode and receiver enable change in one write
            cmd_r.mode  <= hwdata[CMD_MODE_LSB +: 2];
            cmd_r.rx_en <= hwdata[CMD_RXEN];
            cmd_r.tx_en <= hwdata[CMD_TXEN];
         end
         if (wr_mode) begin
            cfg_r <= cfg_t'({hwdata[MODE_SL_LSB +: 2], hwdata[MODE_PEN],
                             hwdata[MODE_PODD]});
         end
         if (wr_ien) begin
            ien_r <= hwdata[2:0];
         end
      end
   end

   // ------------------------------------------------------------
   // Line input synchroniser
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_s1_r <= 1'b1;
         rx_s2_r <= 1'b1;
      end else if (ce) begin
         rx_s1_r <= rx_line;
         rx_s2_r <= rx_s1_r;
      end
   end

   // ------------------------------------------------------------
   // Receiver
   // ------------------------------------------------------------
   wire rx_go    = (rx_st_r == S_IDLE) && rx_run && !rx_in;
   wire rx_done  = (rx_st_r == S_STOP) && rx_mid;
   wire rx_bad   = (rx_st_r == S_START) && rx_mid && rx_in;

   bit_timer u_rx_timer (
      .hclk    (hclk),
      .hresetn (hresetn),
      .ce      (ce),
      .restart (rx_go),
      .mid     (rx_mid),
      .full    (rx_full)
   );

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_st_r  <= S_IDLE;
         rx_bit_r <= 3'h0;
         rx_sh_r  <= 8'h00;
         rx_par_r <= 1'b0;
      end else if (ce) begin
         case (rx_st_r)
            S_IDLE: begin
               if (rx_go) begin
                  rx_st_r <= S_START;
               end
            end
            S_START: begin
               if (rx_bad) begin
                  rx_st_r <= S_IDLE;
               end else if (rx_full) begin
                  rx_st_r  <= S_DATA;
                  rx_bit_r <= 3'h0;
               end
            end
            S_DATA: begin
               if (rx_mid) begin
                  rx_sh_r <= {rx_in, rx_sh_r[7:1]};
               end
               if (rx_full) begin
                  rx_bit_r <= rx_bit_r + 3'h1;
                  if (rx_bit_r == LAST_BIT) begin
                     rx_st_r <= cfg_r.par_en ? S_PAR : S_STOP;
                  end
               end
            end
            S_PAR: begin
               if (rx_mid) begin
                  rx_par_r <= rx_in;
               end
               if (rx_full) begin
                  rx_st_r <= S_STOP;
               end
            end
            S_STOP: begin
               if (rx_done) begin
                  rx_st_r <= S_IDLE;
               end
            end
            default: rx_st_r <= S_IDLE;
         endcase
      end
   end

   // Set by a completed character wins over the clearing read
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         receive_ready_r <= 1'b0;
         rx_data_r       <= 8'h00;
      end else if (ce) begin
         if (rx_done) begin
            receive_ready_r <= 1'b1;
            rx_data_r       <= rx_sh_r;
         end else if (rd_data) begin
            receive_ready_r <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Transmitter
   // ------------------------------------------------------------
   wire tx_idle   = (tx_st_r == S_IDLE);
   wire go_echo   = tx_idle && echo_path && echo_pend_r;
   wire go_norm   = tx_idle && !echo_path && cmd_r.tx_en && thr_full_r;
   wire tx_go     = go_echo || go_norm;
   wire [7:0] src = go_echo ? rx_data_r : thr_r;
   // Underrun point: start of last data bit, or parity bit if enabled
   wire last_beg  = tx_full && (
      ((tx_st_r == S_DATA) && !cfg_r.par_en && (tx_bit_r == LAST_BIT - 3'h1)) ||
      ((tx_st_r == S_DATA) && cfg_r.par_en && (tx_bit_r == LAST_BIT)));
   // Switch point: end of parity (or last data) bit, or of first stop bit
   wire end_pbit  = tx_full && (cfg_r.par_en ? (tx_st_r == S_PAR) :
                    ((tx_st_r == S_DATA) && (tx_bit_r == LAST_BIT)));
   wire end_stop1 = tx_full && (tx_st_r == S_STOP) && !tx_stopn_r;
   wire sw_mark   = two_stop ? end_stop1 : end_pbit;

   bit_timer u_tx_timer (
      .hclk    (hclk),
      .hresetn (hresetn),
      .ce      (ce),
      .restart (tx_go),
      .mid     (tx_mid),
      .full    (tx_full)
   );

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_st_r    <= S_IDLE;
         tx_bit_r   <= 3'h0;
         tx_stopn_r <= 1'b0;
         tx_sh_r    <= 8'h00;
         tx_par_r   <= 1'b0;
      end else if (ce) begin
         case (tx_st_r)
            S_IDLE: begin
               if (tx_go) begin
                  tx_st_r  <= S_START;
                  tx_sh_r  <= src;
                  tx_par_r <= (^src) ^ cfg_r.par_odd;
               end
            end
            S_START: begin
               if (tx_full) begin
                  tx_st_r  <= S_DATA;
                  tx_bit_r <= 3'h0;
               end
            end
            S_DATA: begin
               if (tx_full) begin
                  tx_bit_r <= tx_bit_r + 3'h1;
                  if (tx_bit_r == LAST_BIT) begin
                     tx_st_r    <= cfg_r.par_en ? S_PAR : S_STOP;
                     tx_stopn_r <= 1'b0;
                  end
               end
            end
            S_PAR: begin
               if (tx_full) begin
                  tx_st_r    <= S_STOP;
                  tx_stopn_r <= 1'b0;
               end
            end
            S_STOP: begin
               if (tx_full) begin
                  tx_stopn_r <= 1'b1;
                  if (!two_stop || tx_stopn_r) begin
                     tx_st_r <= S_IDLE;
                  end
               end
            end
            default: tx_st_r <= S_IDLE;
         endcase
      end
   end

   assign line_nxt = (tx_st_r == S_START) ? 1'b0 :
                   (tx_st_r == S_DATA)  ? tx_sh_r[tx_bit_r] :
                   (tx_st_r == S_PAR)   ? tx_par_r : 1'b1;

   // ------------------------------------------------------------
   // Holding register, echo hand-off, empty tracking
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         thr_r       <= 8'h00;
         thr_full_r  <= 1'b0;
         echo_pend_r <= 1'b0;
         undr_r      <= 1'b0;
         echo_done_r <= 1'b0;
      end else if (ce) begin
         if (wr_data) begin
            thr_r      <= hwdata[7:0];
            thr_full_r <= 1'b1;
         end else if (go_norm) begin
            thr_full_r <= 1'b0;
         end
         // Receive ready and echo hand-off come from the same event
         if (rx_done && echo_path && rx_run) begin
            echo_pend_r <= 1'b1;
         end else if (go_echo || !echo_path) begin
            echo_pend_r <= 1'b0;
         end
         if (wr_data || go_norm) begin
            undr_r <= 1'b0;
         end else if (last_beg || (tx_idle && !thr_full_r)) begin
            undr_r <= !thr_full_r;
         end
         if (go_echo) begin
            echo_done_r <= 1'b0;
         end else if (sw_mark || (tx_idle && !echo_pend_r)) begin
            echo_done_r <= 1'b1;
         end
      end
   end

   // Echo needs tx enable set and rx enable clear; remote loop never
   wire emt_echo = cmd_r.tx_en && !cmd_r.rx_en && echo_done_r;
   wire emt_norm = cmd_r.tx_en && undr_r;
   wire emt_nxt  = echo_mode ? emt_echo :
                   (cmd_r.mode == CM_REMOTE) ? 1'b0 : emt_norm;

   // ------------------------------------------------------------
   // Interrupts and pin outputs
   // ------------------------------------------------------------
   wire [2:0] ev = {tx_empty_r && !prev_emt_r,
                    receive_ready_r && !prev_receive_ready_r,
                    !thr_full_r && !prev_transmit_ready_r};
   // Clear applies before events set, so a same-cycle event stays
   wire [2:0] ist_nxt = (ist_r & ~(wr_iclr ? hwdata[2:0] : 3'h0)) | ev;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_empty_r   <= 1'b0;
         prev_emt_r   <= 1'b0;
         prev_receive_ready_r <= 1'b0;
         // Idle level is ready, so no false event after reset
         prev_transmit_ready_r <= 1'b1;
         ist_r        <= 3'h0;
         irq_r        <= 1'b0;
         tx_line_r    <= 1'b1;
      end else if (ce) begin
         tx_empty_r   <= emt_nxt;
         prev_emt_r   <= tx_empty_r;
         prev_receive_ready_r <= receive_ready_r;
         prev_transmit_ready_r <= !thr_full_r;
         ist_r        <= ist_nxt;
         irq_r        <= |(ist_nxt & ien_r);
         tx_line_r    <= (cmd_r.mode == CM_LOCAL) ? 1'b1 : line_nxt;
      end
   end

   assign hrdata    = hrdata_r;
   assign hreadyout = hreadyout_r;
   assign hresp     = 1'b0;
   assign tx_line   = tx_line_r;
   assign irq       = irq_r;
   assign tx_empty_or_line_change_pin_n = !tx_empty_r;
endmodule // serial_mode_ctrl
`default_nettype wire

// ==== verification/remote_station.sv ====
// Purpose: Remote serial station on the line side
// Assumes: 8 data bits LSB first; parity and stop bits not sampled
// Notes:   Line idles high between frames
`timescale 1ns/1ps
`default_nettype none
module remote_station
   import mode_pkg::*;
(
   // Serial line
   input  wire logic tx_line,
   output logic      rx_line
);
   localparam real BIT_T = 5.0 * BIT_CYC;
   logic [7:0] got_q[$];
   logic [7:0] ch;
   realtime    start_t;
   initial rx_line = 1'b1;
   task automatic send(input logic [7:0] c);
      // Off the clock edge
      #1;
      rx_line = 1'b0;
      #(BIT_T);
      for (int i = 0; i < 8; i++) begin
         rx_line = c[i];
         #(BIT_T);
      end
      rx_line = 1'b1;
      #(BIT_T);
   endtask
   // Sample mid bit, LSB first
   always begin
      @(negedge tx_line);
      start_t = $realtime;
      #(BIT_T * 1.5);
      for (int i = 0; i < 8; i++) begin
         ch[i] = tx_line;
         #(BIT_T);
      end
      got_q.push_back(ch);
   end
endmodule // remote_station
`default_nettype wire

// ==== verification/serial_mode_switch_control_test.sv ====
// Purpose: Self-checking bench for serial_mode_ctrl
// Assumes: 200 MHz hclk, 8N1, 8N2 and 8E1 frames
// Notes:   Timing expectations derive from BIT_CYC
`timescale 1ns/1ps
`default_nettype none
module serial_mode_switch_control_test
   import mode_pkg::*;
;
   localparam int B = int'(BIT_CYC);
   logic        hclk, hresetn, ce, hsel, hwrite;
   logic [31:0] haddr, hwdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   wire logic   hreadyout, hresp, tx_line, rx_line, pin_n, irq;
   wire logic [31:0] hrdata;
   wire logic   hready = hreadyout;
   int          err_total = 0;
   int          n_checks = 0;
   int          cyc = 0;
   serial_mode_ctrl DUT (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rx_line(rx_line),
      .tx_line(tx_line), .tx_empty_or_line_change_pin_n(pin_n), .irq(irq));
   remote_station rs (.tx_line(tx_line), .rx_line(rx_line));
   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 98000) begin
         err_total++;
         $display("ERROR %0t run too long", $time);
         summarize();
      end
   end
   task automatic summarize;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t %s got %0h exp %0h", $time, what, got, exp);
      end
   endtask
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {24'h0, a};
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wait_stat(input int b);
      for (int i = 0; i < 8000; i++) begin
         xfer(A_STAT, 1'b0, 32'h0);
         if (rd[b] === 1'b1) return;
      end
      chk(32'h0, 32'h1, "status wait");
   endtask
   // Cycles from frame start to empty pin going active
   task automatic empty_at(input int bits);
      int n;
      for (n = 0; n < 20000 && pin_n !== 1'b0; n++) @(posedge hclk);
      n = int'(($realtime - rs.start_t) / 5.0);
      chk(32'(n >= bits * B - 3 && n <= bits * B + 3), 32'h1, "empty timing");
   endtask
   task automatic expect_char(input logic [7:0] c);
      for (int i = 0; i < 12 * B && rs.got_q.size() == 0; i++) @(posedge hclk);
      if (rs.got_q.size() == 0)
         chk(32'h0, 32'h1, "no char on line");
      else
         chk({24'h0, rs.got_q.pop_front()}, {24'h0, c}, "line char");
   endtask
   task automatic t_reset;
      xfer(A_CMD, 1'b0, 32'h0);
      chk(rd, 32'h0, "CMD reset");
      xfer(A_MODE, 1'b0, 32'h0);
      chk(rd, {24'h0, MODE_RST}, "MODE reset");
      xfer(8'h1C, 1'b0, 32'h0);
      chk(rd, 32'h0, "unmapped read");
      xfer(A_ICLR, 1'b1, 32'h7);
   endtask
   task automatic t_normal;
      xfer(A_CMD, 1'b1, 32'h1);
      repeat (4) @(posedge hclk);
      chk({31'h0, pin_n}, 32'h0, "idle empty");
      xfer(A_DATA, 1'b1, 32'hA5);
      repeat (4 * B) @(posedge hclk);
      empty_at(8);
      expect_char(8'hA5);
   endtask
   task automatic t_echo;
      xfer(A_CMD, 1'b1, 32'h0);
      repeat (4) @(posedge hclk);
      chk({31'h0, pin_n}, 32'h1, "empty after disable");
      xfer(A_MODE, 1'b1, 32'h3);
      xfer(A_CMD, 1'b1, 32'h44);
      xfer(A_IEN, 1'b1, 32'h2);
      fork
         rs.send(8'h3C);
      join_none
      for (int i = 0; i < 12 * B && irq !== 1'b1; i++) @(posedge hclk);
      chk({31'h0, irq}, 32'h1, "rx irq");
      wait_stat(ST_RECEIVE_READY);
      xfer(A_DATA, 1'b0, 32'h0);
      chk(rd, 32'h3C, "rx char");
      xfer(A_CMD, 1'b1, 32'h45);
      xfer(A_CMD, 1'b1, 32'h41);
      xfer(A_ICLR, 1'b1, 32'h2);
      repeat (3) @(posedge hclk);
      chk({31'h0, irq}, 32'h0, "irq cleared");
      repeat (4 * B) @(posedge hclk);
      empty_at(10);
      expect_char(8'h3C);
      xfer(A_CMD, 1'b1, 32'h1);
      xfer(A_MODE, 1'b1, 32'h4);
      xfer(A_MODE, 1'b0, 32'h0);
      chk(rd, 32'h4, "MODE write");
      xfer(A_DATA, 1'b1, 32'h5A);
      repeat (8) @(posedge hclk);
      empty_at(9);
      expect_char(8'h5A);
   endtask
   task automatic t_remote;
      chk({31'h0, pin_n}, 32'h0, "empty before disable");
      xfer(A_CMD, 1'b1, 32'h0);
      repeat (4) @(posedge hclk);
      chk({31'h0, pin_n}, 32'h1, "empty after disable");
      xfer(A_CMD, 1'b1, 32'hC5);
      repeat (4) @(posedge hclk);
      chk({31'h0, pin_n}, 32'h1, "empty in remote");
      xfer(A_CMD, 1'b1, 32'h41);
      repeat (4) @(posedge hclk);
      chk({31'h0, pin_n}, 32'h0, "empty after remote exit");
      xfer(A_CMD, 1'b1, 32'h1);
   endtask
   initial begin
      hresetn = 1'b0;
      ce      = 1'b1;
      hsel    = 1'b0;
      haddr   = 32'h0;
      htrans  = 2'h0;
      hwrite  = 1'b0;
      hsize   = 3'h2;
      hwdata  = 32'h0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      t_reset();
      t_normal();
      t_echo();
      t_remote();
      summarize();
   end
endmodule // serial_mode_switch_control_test
`default_nettype wire

// ==== verification/smc_assertions.sv ====
// Purpose: Port checker for serial_mode_ctrl
// Assumes: ce held high by the bench
// Notes:   Shadows CMD and IEN from bus writes
`timescale 1ns/1ps
`default_nettype none
module smc_assertions
   import mode_pkg::*;
(
   // Clock and reset
   input wire logic        hclk,
   input wire logic        hresetn,
   // Bus
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   // Pins
   input wire logic        tx_line,
   input wire logic        tx_empty_or_line_change_pin_n,
   input wire logic        irq
);
   // ------------------------------------------------------------
   // Bus shadow
   // ------------------------------------------------------------
   logic        ap_r, wr_r, tx_r;
   logic [7:0]  a_r;
   logic [2:0]  ien_r;
   logic [11:0] run_r;
   cmd_t        cmd_r;
   wire logic   wcmd = ap_r && wr_r && a_r == A_CMD;
   wire logic   rcmd = ap_r && !wr_r && a_r == A_CMD;
   wire logic   wien = ap_r && wr_r && a_r == A_IEN;
   wire logic   pin  = tx_empty_or_line_change_pin_n;
   wire logic   echo_txoff = cmd_r.mode == CM_ECHO && !cmd_r.tx_en;
   wire logic   echo_rxon  = cmd_r.mode == CM_ECHO && cmd_r.rx_en;
   wire logic   norm_txoff = cmd_r.mode == CM_NORMAL && !cmd_r.tx_en;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_r  <= 1'b0;
         wr_r  <= 1'b0;
         a_r   <= 8'h00;
         cmd_r <= '0;
         ien_r <= 3'h0;
      end else if (hready) begin
         ap_r  <= hsel && htrans[1];
         wr_r  <= hwrite;
         a_r   <= haddr[7:0];
         cmd_r <= wcmd ? {hwdata[7:6], hwdata[2], hwdata[0]} : cmd_r;
         ien_r <= wien ? hwdata[2:0] : ien_r;
      end
   end
   // Length of the current level on the line
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_r  <= 1'b1;
         run_r <= 12'h000;
      end else begin
         tx_r  <= tx_line;
         run_r <= (tx_line != tx_r) ? 12'h001 : run_r + {11'h000, run_r != 12'hFFF};
      end
   end
   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Pin may lag its cause by up to three cycles
   sequence s_held(logic c);
      c [*4];
   endsequence
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("hresp not OKAY");
   a_ready_up: assert property ($past(hresetn) |-> hreadyout)
      else $error("hreadyout low after reset");
   a_cmd_readback: assert property (rcmd && hready |->
      (hrdata & 32'h000000C5) == {24'h0, cmd_r.mode, 3'h0, cmd_r.rx_en, 1'b0, cmd_r.tx_en})
      else $error("CMD readback wrong");
   a_low_run_width: assert property (tx_line && !tx_r |-> run_r >= BIT_CYC - 12'h001)
      else $error("tx bit shorter than a bit time");
   a_echo_txoff_quiet: assert property (s_held(echo_txoff) |-> pin)
      else $error("empty active in echo with tx off");
   a_echo_rxon_quiet: assert property (s_held(echo_rxon) |-> pin)
      else $error("empty active in echo with rx on");
   a_txoff_no_empty: assert property (s_held(norm_txoff) |-> pin)
      else $error("empty active with tx disabled");
   a_irq_masked: assert property (s_held(ien_r == 3'h0) |-> !irq)
      else $error("irq with all sources masked");
endmodule // smc_assertions

bind serial_mode_ctrl smc_assertions chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .tx_line(tx_line),
   .tx_empty_or_line_change_pin_n(tx_empty_or_line_change_pin_n), .irq(irq));
`default_nettype wire
